// >>> logic/plcd_consts.svh
`ifndef PLCD_CONSTS_SVH
`define PLCD_CONSTS_SVH

// Register byte addresses (low eight address bits)
`define PLCD_ADDR_LOCK 8'h00
`define PLCD_ADDR_TUNE 8'h04
`define PLCD_ADDR_PEAK 8'h08
`define PLCD_ADDR_FILT 8'h0c
`define PLCD_ADDR_SYNTH 8'h10
`define PLCD_ADDR_RES_A 8'h14
`define PLCD_ADDR_RES_B 8'h18
`define PLCD_ADDR_MANCH 8'h1c

// Reset values
`define PLCD_RST_LOCK 8'h00
`define PLCD_RST_TUNE 8'h05
`define PLCD_RST_PEAK 8'h96
`define PLCD_RST_FILT 8'h67

// Field positions
`define PLCD_LOCK_SEL_HI 7
`define PLCD_LOCK_SEL_LO 4
`define PLCD_LOCK_ACC 3
`define PLCD_LOCK_LEN 2
`define PLCD_TUNE_START 7
`define PLCD_TUNE_DUAL 6
`define PLCD_TUNE_WAIT 5
`define PLCD_TUNE_CUR 4
`define PLCD_TUNE_DONE 3
`define PLCD_PEAK_EN 7
`define PLCD_FILT_LIM_HI 7
`define PLCD_FILT_LIM_LO 5
`define PLCD_FILT_HOLD 4
`define PLCD_FILT_MAN 3
`define PLCD_FILT_SET_HI 2
`define PLCD_FILT_SET_LO 1
`define PLCD_FILT_RSTN 0

// Lock pin source codes
`define PLCD_PIN_CHP 4'h0
`define PLCD_PIN_SUST 4'h1
`define PLCD_PIN_MOM 4'h2
`define PLCD_PIN_ALH 4'h3
`define PLCD_PIN_ALL 4'h4
`define PLCD_PIN_DONE 4'h5
`define PLCD_PIN_IF 4'h6
`define PLCD_PIN_REF 4'h7
`define PLCD_PIN_PA 4'h8
`define PLCD_PIN_VIOL 4'h9
`define PLCD_PIN_LNA 4'ha
`define PLCD_PIN_UND0 4'hb
`define PLCD_PIN_UND1 4'hc
`define PLCD_PIN_AVG 4'hd
`define PLCD_PIN_NDIV 4'he
`define PLCD_PIN_FCMP 4'hf

// Lock detector thresholds and window lengths (last window index)
`define PLCD_LOCK_SET_FINE 7'h7f
`define PLCD_LOCK_REL_FINE 7'h6f
`define PLCD_LOCK_SET_COARSE 7'h1f
`define PLCD_LOCK_REL_COARSE 7'h0f
`define PLCD_WIN_SHORT 3'h3
`define PLCD_WIN_LONG 3'h7

// Manchester quality
`define PLCD_MQ_MAX 4'he

// Settling times in baud
`define PLCD_SETTLE_0 7'h0b
`define PLCD_SETTLE_1 7'h16
`define PLCD_SETTLE_2 7'h2b
`define PLCD_SETTLE_3 7'h56

// Timing
`define PLCD_CLK_NS 10
`define PLCD_CAL_HALF_WAIT_NS 2000
`define PLCD_CAL_HALF_WAIT_CYC \
  ((`PLCD_CAL_HALF_WAIT_NS + `PLCD_CLK_NS - 1) / `PLCD_CLK_NS)

// AXI responses
`define PLCD_RESP_OKAY 2'h0
`define PLCD_RESP_SLVERR 2'h2

`endif

// >>> logic/plcd_pkg.sv
package plcd_pkg;

  typedef struct packed {
    logic pre_clk;
    logic phase_err;
    logic cal_cmp;
    logic alarm_high;
    logic alarm_low;
    logic charge_pump_output_pin;
    logic if_out;
    logic ref_div_out;
    logic n_div_out;
    logic f_comp;
    logic external_pa_enable;
    logic external_lna_enable;
  } plcd_pins_type;

  typedef struct packed {
    logic demod_reset_n;
    logic peak_remover_enable;
    logic [6:0] peak_threshold;
    logic [6:0] settle_baud;
    logic avg_filter_locked_out;
  } plcd_demod_type;

  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_SET = 4'b0010,
    CAL_WAIT = 4'b0100,
    CAL_DECIDE = 4'b1000
  } plcd_cal_state_type;

endpackage

// >>> logic/plcd_top.sv
`timescale 1ns/10ps
// What this block does
// - Lock pin shows the source picked by the 4-bit select; codes 1011, 1100 give 0.
// - Fine threshold: lock declared at count 127, released at count 111.
// - Coarse threshold: lock declared at count 31, released at count 15.
// - Lock window is 4 prescaler cycles, or 8 with the length bit set.
// - Momentary and sustained lock flags read back in bits one and zero.
// - A zero-to-one write of the trigger bit starts calibration.
// - Result stored in both sets when store-both set, else in selected set.
// - Wait bit picks full (doubled) wait when 1, half wait when 0.
// - Current bit doubles calibration current when 1.
// - Tuning done bit, bit three, is set when calibration finishes.
// - DAC iteration start is field code plus one; reset code is 101.
// - Peak remover enable bit, reset to enabled.
// - Seven-bit peak threshold field, reset 0010110.
// - Bit quality is rated 0 to 14; 14 perfect, 0 constant level.
// - Violation flag when quality below limit k; limit 000 never flags.
// - Filter hold bit locks the filter, only in manual mode.
// - Filter mode bit: 0 automatic lock, 1 follows the hold bit.
// - Settling code selects 11, 22, 43 or 86 baud; reset 86.
// - Active-low demodulator reset bit, reset to 1; writing 0 holds reset.
// - Tuning high and low alarm status bits read back.
`include "plcd_consts.svh"
module plcd_top
  import plcd_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog and divider pins, asynchronous
  input wire plcd_pins_type pins_async,
  // Demodulator side, same clock
  input wire logic [3:0] mq_value,
  input wire logic mq_valid,
  input wire logic auto_avg_lock,
  input wire logic freq_set_b,
  // Outputs
  output logic lock_pin,
  output logic cal_current_double,
  output logic [7:0] cal_dac,
  output logic manchester_violation,
  output plcd_demod_type demod
);

  function automatic logic [6:0] lock_thr(input logic coarse, input logic release_thr);
    if (coarse)
      lock_thr = release_thr ? `PLCD_LOCK_REL_COARSE : `PLCD_LOCK_SET_COARSE;
    else
      lock_thr = release_thr ? `PLCD_LOCK_REL_FINE : `PLCD_LOCK_SET_FINE;
  endfunction

  function automatic logic [6:0] settle_baud(input logic [1:0] code);
    case (code)
      2'h0: settle_baud = `PLCD_SETTLE_0;
      2'h1: settle_baud = `PLCD_SETTLE_1;
      2'h2: settle_baud = `PLCD_SETTLE_2;
      default: settle_baud = `PLCD_SETTLE_3;
    endcase
  endfunction

  // Pin synchroniser; stage one feeds only stage two
  plcd_pins_type pins_meta;
  plcd_pins_type pins;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_meta <= '0;
      pins <= '0;
    end else begin
      pins_meta <= pins_async;
      pins <= pins_meta;
    end
  end

  // Register storage
  logic [7:0] lock_ctl;
  logic [7:0] tune_ctl;
  logic [7:0] peak_ctl;
  logic [7:0] filt_ctl;
  logic [7:0] res_a;
  logic [7:0] res_b;
  logic [3:0] last_q;
  logic mom_lock;
  logic sust_lock;
  logic cal_done;

  // AXI write channel
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [7:0] w_byte;
  logic w_en;
  logic wr_fire;
  logic wr_mapped;
  logic start_pulse;

  assign wr_fire = aw_hold && w_hold && !bvalid;
  assign wr_mapped = (aw_addr == `PLCD_ADDR_LOCK) || (aw_addr == `PLCD_ADDR_TUNE) ||
                     (aw_addr == `PLCD_ADDR_PEAK) || (aw_addr == `PLCD_ADDR_FILT);
  assign start_pulse = wr_fire && w_en && (aw_addr == `PLCD_ADDR_TUNE) &&
                       w_byte[`PLCD_TUNE_START] && !tune_ctl[`PLCD_TUNE_START];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_en <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `PLCD_RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold <= 1'b1;
        aw_addr <= awaddr[7:0] | {6'h00, awaddr[1:0]} | (|awaddr[31:8] ? 8'h01 : 8'h00);
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_hold <= 1'b1;
        w_byte <= wdata[7:0];
        w_en <= wstrb[0];
        wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_mapped ? `PLCD_RESP_OKAY : `PLCD_RESP_SLVERR;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (!aw_hold && !w_hold && !bvalid && !awready && !wready) begin
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Register writes; status bits are not writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_ctl <= `PLCD_RST_LOCK;
      tune_ctl <= `PLCD_RST_TUNE;
      peak_ctl <= `PLCD_RST_PEAK;
      filt_ctl <= `PLCD_RST_FILT;
    end else if (wr_fire && w_en) begin
      unique case (aw_addr)
        `PLCD_ADDR_LOCK: lock_ctl <= {w_byte[7:2], 2'h0};
        `PLCD_ADDR_TUNE: tune_ctl <= {w_byte[7:4], 1'b0, w_byte[2:0]};
        `PLCD_ADDR_PEAK: peak_ctl <= w_byte;
        `PLCD_ADDR_FILT: filt_ctl <= w_byte;
        default: ;
      endcase
    end
  end

  // AXI read channel
  logic [31:0] next_rdata;
  logic rd_mapped;
  always_comb begin
    next_rdata = 32'h0000_0000;
    rd_mapped = 1'b1;
    if (|araddr[31:8] || |araddr[1:0]) begin
      rd_mapped = 1'b0;
    end else begin
      unique case (araddr[7:0])
        `PLCD_ADDR_LOCK: next_rdata[7:0] = {lock_ctl[7:2], mom_lock, sust_lock};
        `PLCD_ADDR_TUNE: next_rdata[7:0] = {tune_ctl[7:4], cal_done, tune_ctl[2:0]};
        `PLCD_ADDR_PEAK: next_rdata[7:0] = peak_ctl;
        `PLCD_ADDR_FILT: next_rdata[7:0] = filt_ctl;
        `PLCD_ADDR_SYNTH: next_rdata[7:0] = {6'h00, pins.alarm_high, pins.alarm_low};
        `PLCD_ADDR_RES_A: next_rdata[7:0] = res_a;
        `PLCD_ADDR_RES_B: next_rdata[7:0] = res_b;
        `PLCD_ADDR_MANCH: next_rdata[7:0] = {3'h0, manchester_violation, last_q};
        default: rd_mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PLCD_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_mapped ? `PLCD_RESP_OKAY : `PLCD_RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Lock detector, stepped by prescaler clock edges seen through the synchroniser
  logic pre_last;
  logic pre_tick;
  logic [2:0] win_cnt;
  logic win_bad;
  logic [6:0] lock_cnt;
  logic win_end;
  logic [6:0] next_lock_cnt;
  logic coarse;

  assign pre_tick = pins.pre_clk && !pre_last;
  assign coarse = lock_ctl[`PLCD_LOCK_ACC];
  assign win_end = pre_tick && (win_cnt == (lock_ctl[`PLCD_LOCK_LEN] ?
                   `PLCD_WIN_LONG : `PLCD_WIN_SHORT));

  always_comb begin
    next_lock_cnt = lock_cnt;
    if (win_end) begin
      if (!win_bad && !pins.phase_err) begin
        if (lock_cnt < lock_thr(coarse, 1'b0))
          next_lock_cnt = lock_cnt + 7'h01;
      end else if (lock_cnt != 7'h00) begin
        next_lock_cnt = lock_cnt - 7'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_last <= 1'b0;
      win_cnt <= 3'h0;
      win_bad <= 1'b0;
      lock_cnt <= 7'h00;
      mom_lock <= 1'b0;
      sust_lock <= 1'b0;
    end else begin
      pre_last <= pins.pre_clk;
      lock_cnt <= next_lock_cnt;
      if (win_end) begin
        win_cnt <= 3'h0;
        win_bad <= 1'b0;
        mom_lock <= !win_bad && !pins.phase_err;
      end else if (pre_tick) begin
        win_cnt <= win_cnt + 3'h1;
        win_bad <= win_bad | pins.phase_err;
      end
      if (next_lock_cnt >= lock_thr(coarse, 1'b0))
        sust_lock <= 1'b1;
      else if (next_lock_cnt <= lock_thr(coarse, 1'b1))
        sust_lock <= 1'b0;
    end
  end

  AST_LOCK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(sust_lock) |-> lock_cnt >= lock_thr(coarse, 1'b0))
    else $error("Lock declared below threshold");
  AST_LOCK_REL: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(sust_lock) |-> lock_cnt <= lock_thr(coarse, 1'b1))
    else $error("Lock released above threshold");
  AST_WINDOW: assert property (@(posedge aclk) disable iff (!aresetn)
    win_end && !lock_ctl[`PLCD_LOCK_LEN] |-> win_cnt == 3'h3)
    else $error("Short lock window not four edges");

  // Calibration sequencer, successive approximation on the tuning DAC
  plcd_cal_state_type cal_state;
  logic [2:0] bit_idx;
  logic [3:0] iter_left;
  logic [9:0] wait_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cal_state <= CAL_IDLE;
      bit_idx <= 3'h0;
      iter_left <= 4'h0;
      wait_cnt <= 10'h000;
      cal_dac <= 8'h00;
      cal_done <= 1'b0;
      res_a <= 8'h00;
      res_b <= 8'h00;
    end else begin
      unique case (cal_state)
        CAL_IDLE: begin
          if (start_pulse) begin
            cal_done <= 1'b0;
            cal_dac <= 8'h00;
            // Take the code written with the trigger, not the one stored before it
            bit_idx <= w_byte[2:0];
            iter_left <= {1'b0, w_byte[2:0]} + 4'h1;
            cal_state <= CAL_SET;
          end
        end
        CAL_SET: begin
          cal_dac[bit_idx] <= 1'b1;
          // Half wait, or the full doubled wait
          wait_cnt <= tune_ctl[`PLCD_TUNE_WAIT] ? 10'(2 * `PLCD_CAL_HALF_WAIT_CYC - 1) :
                      10'(`PLCD_CAL_HALF_WAIT_CYC - 1);
          cal_state <= CAL_WAIT;
        end
        CAL_WAIT: begin
          if (wait_cnt == 10'h000)
            cal_state <= CAL_DECIDE;
          else
            wait_cnt <= wait_cnt - 10'h001;
        end
        CAL_DECIDE: begin
          if (!pins.cal_cmp)
            cal_dac[bit_idx] <= 1'b0;
          iter_left <= iter_left - 4'h1;
          bit_idx <= bit_idx - 3'h1;
          if (iter_left == 4'h1) begin
            cal_done <= 1'b1;
            cal_state <= CAL_IDLE;
            if (tune_ctl[`PLCD_TUNE_DUAL] || !freq_set_b) begin
              res_a <= pins.cal_cmp ? cal_dac : cal_dac & ~(8'h01 << bit_idx);
            end
            if (tune_ctl[`PLCD_TUNE_DUAL] || freq_set_b) begin
              res_b <= pins.cal_cmp ? cal_dac : cal_dac & ~(8'h01 << bit_idx);
            end
          end else begin
            cal_state <= CAL_SET;
          end
        end
        default: cal_state <= CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      cal_current_double <= 1'b0;
    else
      cal_current_double <= tune_ctl[`PLCD_TUNE_CUR];
  end

  AST_CAL_START: assert property (@(posedge aclk) disable iff (!aresetn)
    start_pulse && cal_state == CAL_IDLE |=> !cal_done && cal_state == CAL_SET)
    else $error("Calibration trigger not taken");
  AST_CAL_ITER: assert property (@(posedge aclk) disable iff (!aresetn)
    start_pulse && cal_state == CAL_IDLE |=> iter_left == {1'b0, $past(w_byte[2:0])} + 4'h1)
    else $error("Iteration start not code plus one");
  AST_CAL_WAIT: assert property (@(posedge aclk) disable iff (!aresetn)
    cal_state == CAL_SET && !tune_ctl[`PLCD_TUNE_WAIT] |=> wait_cnt == 10'd199)
    else $error("Half calibration wait wrong");

  // Manchester violation detector and averaging filter
  logic [3:0] q_clamped;
  logic [2:0] limit;
  assign q_clamped = (mq_value > `PLCD_MQ_MAX) ? `PLCD_MQ_MAX : mq_value;
  assign limit = filt_ctl[`PLCD_FILT_LIM_HI:`PLCD_FILT_LIM_LO];

  always_ff @(posedge aclk) begin
    if (!aresetn || !filt_ctl[`PLCD_FILT_RSTN]) begin
      manchester_violation <= 1'b0;
      last_q <= 4'h0;
    end else if (mq_valid) begin
      last_q <= q_clamped;
      manchester_violation <= (limit != 3'h0) && (q_clamped < {1'b0, limit});
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demod <= '0;
    end else begin
      demod.demod_reset_n <= filt_ctl[`PLCD_FILT_RSTN];
      demod.peak_remover_enable <= peak_ctl[`PLCD_PEAK_EN];
      demod.peak_threshold <= peak_ctl[6:0];
      demod.settle_baud <= settle_baud(filt_ctl[`PLCD_FILT_SET_HI:`PLCD_FILT_SET_LO]);
      if (!filt_ctl[`PLCD_FILT_RSTN])
        demod.avg_filter_locked_out <= 1'b0;
      else if (filt_ctl[`PLCD_FILT_MAN])
        demod.avg_filter_locked_out <= filt_ctl[`PLCD_FILT_HOLD];
      else
        demod.avg_filter_locked_out <= auto_avg_lock;
    end
  end

  AST_VIOL_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    mq_valid && limit == 3'h0 |=> !manchester_violation)
    else $error("Violation flagged with limit zero");
  AST_VIOL_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    mq_valid && filt_ctl[0] && mq_value == 4'h0 && limit != 3'h0 |=> manchester_violation)
    else $error("Constant level not flagged");
  AST_AVG_MANUAL: assert property (@(posedge aclk) disable iff (!aresetn)
    filt_ctl[`PLCD_FILT_MAN] && filt_ctl[0] |=>
      demod.avg_filter_locked_out == $past(filt_ctl[`PLCD_FILT_HOLD]))
    else $error("Manual filter lock not following hold bit");

  // Lock pin selector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_pin <= 1'b0;
    end else begin
      unique case (lock_ctl[`PLCD_LOCK_SEL_HI:`PLCD_LOCK_SEL_LO])
        `PLCD_PIN_CHP: lock_pin <= pins.charge_pump_output_pin;
        `PLCD_PIN_SUST: lock_pin <= sust_lock;
        `PLCD_PIN_MOM: lock_pin <= mom_lock;
        `PLCD_PIN_ALH: lock_pin <= pins.alarm_high;
        `PLCD_PIN_ALL: lock_pin <= pins.alarm_low;
        `PLCD_PIN_DONE: lock_pin <= cal_done;
        `PLCD_PIN_IF: lock_pin <= pins.if_out;
        `PLCD_PIN_REF: lock_pin <= pins.ref_div_out;
        `PLCD_PIN_PA: lock_pin <= pins.external_pa_enable;
        `PLCD_PIN_VIOL: lock_pin <= manchester_violation;
        `PLCD_PIN_LNA: lock_pin <= pins.external_lna_enable;
        `PLCD_PIN_UND0: lock_pin <= 1'b0;
        `PLCD_PIN_UND1: lock_pin <= 1'b0;
        `PLCD_PIN_AVG: lock_pin <= demod.avg_filter_locked_out;
        `PLCD_PIN_NDIV: lock_pin <= pins.n_div_out;
        `PLCD_PIN_FCMP: lock_pin <= pins.f_comp;
      endcase
    end
  end

  AST_PIN_UNDEF: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_ctl[7:4] == 4'hb || lock_ctl[7:4] == 4'hc |=> !lock_pin)
    else $error("Undefined pin code drives high");
  AST_PIN_SUST: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_ctl[7:4] == 4'h1 |=> lock_pin == $past(sust_lock))
    else $error("Lock pin not showing sustained lock");

endmodule

// >>> test/plcd_rf_model.sv
`timescale 1ns/10ps
module plcd_rf_model
  import plcd_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Bench controls
  input wire logic phase_bad,
  input wire logic [7:0] target,
  // Synthesizer side
  input wire logic [7:0] cal_dac,
  output logic pre_clk,
  output logic phase_err,
  output logic cal_cmp
);
  logic [1:0] div;

  initial begin
    div = 2'h0;
    pre_clk = 1'b0;
    phase_err = 1'b0;
    cal_cmp = 1'b0;
  end

  // Prescaler runs free: one rising edge every four cycles
  always @(posedge aclk) begin
    div <= div + 2'h1;
    pre_clk <= div[1];
    phase_err <= phase_bad;
    // Comparator stays high while the trial word is not above the tuning target
    cal_cmp <= (cal_dac <= target);
  end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/10ps
`include "plcd_consts.svh"
module tb_top;
  import plcd_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] wstrb = 4'h0, mq_value = 4'h0;
  logic [1:0] bresp, rresp, r;
  logic mq_valid = 1'b0, auto_avg_lock = 1'b0, freq_set_b = 1'b0, phase_bad = 1'b0;
  logic [7:0] target = 8'h0, cal_dac;
  logic [8:0] pins9 = 9'h0;
  logic pre_clk, phase_err, cal_cmp, lock_pin, cal_current_double, manchester_violation;
  plcd_demod_type demod;
  int fail_count = 0, cmp_count = 0, cyc = 0;

  always #5 aclk = ~aclk;

  plcd_rf_model rf (.aclk(aclk), .phase_bad(phase_bad), .target(target), .cal_dac(cal_dac),
    .pre_clk(pre_clk), .phase_err(phase_err), .cal_cmp(cal_cmp));

  plcd_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pins_async(plcd_pins_type'({pre_clk, phase_err, cal_cmp, pins9})),
    .mq_value(mq_value), .mq_valid(mq_valid), .auto_avg_lock(auto_avg_lock),
    .freq_set_b(freq_set_b), .lock_pin(lock_pin), .cal_current_double(cal_current_double),
    .cal_dac(cal_dac), .manchester_violation(manchester_violation), .demod(demod));

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic do_reset();
    aresetn <= 1'b0;
    cyc_wait(12);
    aresetn <= 1'b1;
    cyc_wait(2);
  endtask

  // Both channels offered together; each is released at its own handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    bit aw, w;
    awaddr <= {24'h0, a};
    wdata <= {24'h0, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    aw = 0;
    w = 0;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic rd(input logic [7:0] a);
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(d & m, e);
  endtask

  task automatic t_reset_bus();
    rchk(`PLCD_ADDR_LOCK, 32'hfffffffc, 32'h0);
    rchk(`PLCD_ADDR_TUNE, 32'hffffffff, 32'h05);
    rchk(`PLCD_ADDR_PEAK, 32'hffffffff, 32'h96);
    rchk(`PLCD_ADDR_FILT, 32'hffffffff, 32'h67);
    chk({15'h0, demod}, {15'h0, 1'b1, 1'b1, 7'h16, 7'h56, 1'b0});
    rd(8'h20);
    chk({r, d}, {`PLCD_RESP_SLVERR, 32'h0});
    wr(8'h24, 8'h11, 4'h1);
    chk(r, `PLCD_RESP_SLVERR);
    wr(`PLCD_ADDR_PEAK, 8'h00, 4'h0);
    rchk(`PLCD_ADDR_PEAK, 32'hff, 32'h96);
    // Done bit is status only; a write cannot set it
    wr(`PLCD_ADDR_TUNE, 8'h0d, 4'h1);
    rchk(`PLCD_ADDR_TUNE, 32'hff, 32'h05);
  endtask

  function automatic int pin_idx(input int c);
    case (c)
      0: return 6;
      3: return 8;
      4: return 7;
      6: return 5;
      7: return 4;
      8: return 1;
      10: return 0;
      14: return 3;
      15: return 2;
      11, 12: return 9;
      default: return 99;
    endcase
  endfunction

  task automatic t_pins();
    int p;
    for (int c = 0; c < 16; c++) begin
      p = pin_idx(c);
      if (p == 99) continue;
      wr(`PLCD_ADDR_LOCK, 8'(c << 4), 4'h1);
      for (int v = 0; v < 2; v++) begin
        pins9 <= (p == 9) ? 9'h1ff : (v == 1 ? ~(9'h1 << p) : (9'h1 << p));
        cyc_wait(5);
        chk(lock_pin, (p != 9 && v == 0));
      end
    end
    pins9 <= 9'h100;
    cyc_wait(5);
    rchk(`PLCD_ADDR_SYNTH, 32'h3, 32'h2);
    pins9 <= 9'h080;
    cyc_wait(5);
    rchk(`PLCD_ADDR_SYNTH, 32'h3, 32'h1);
    pins9 <= 9'h0;
  endtask

  // Windows of 16 or 32 cycles; checks sit six windows either side of each threshold
  task automatic t_lock(input bit co, input bit lg);
    int w, n, m;
    w = lg ? 32 : 16;
    n = co ? 31 : 127;
    m = co ? 15 : 111;
    phase_bad <= 1'b0;
    do_reset();
    wr(`PLCD_ADDR_LOCK, {4'h1, co, lg, 2'b00}, 4'h1);
    cyc_wait((n - 6) * w);
    rchk(`PLCD_ADDR_LOCK, 32'h3, 32'h2);
    cyc_wait(12 * w);
    rchk(`PLCD_ADDR_LOCK, 32'h3, 32'h3);
    chk(lock_pin, 1'b1);
    phase_bad <= 1'b1;
    cyc_wait((n - m - 6) * w);
    rchk(`PLCD_ADDR_LOCK, 32'h3, 32'h1);
    cyc_wait(12 * w);
    rchk(`PLCD_ADDR_LOCK, 32'h3, 32'h0);
    chk(lock_pin, 1'b0);
    phase_bad <= 1'b0;
  endtask

  task automatic t_cal(input bit du, input bit wt, input bit cu, input logic [2:0] code,
                       input logic [7:0] tg, input bit sb, input logic [7:0] ea,
                       input logic [7:0] eb);
    int t, n;
    t = (int'(code) + 1) * (wt ? 402 : 202) + 1;
    target <= tg;
    freq_set_b <= sb;
    wr(`PLCD_ADDR_TUNE, {1'b0, du, wt, cu, 1'b0, 3'h0}, 4'h1);
    wr(`PLCD_ADDR_TUNE, {1'b1, du, wt, cu, 1'b0, code}, 4'h1);
    rchk(`PLCD_ADDR_TUNE, 32'h8, 32'h0);
    chk(cal_current_double, cu);
    cyc_wait(t * 3 / 4);
    rchk(`PLCD_ADDR_TUNE, 32'h8, 32'h0);
    n = 0;
    do begin
      rd(`PLCD_ADDR_TUNE);
      n++;
    end while (d[3] !== 1'b1 && n < t / 6 + 10);
    chk(d[3], 1'b1);
    rchk(`PLCD_ADDR_RES_A, 32'hff, ea);
    rchk(`PLCD_ADDR_RES_B, 32'hff, eb);
  endtask

  task automatic t_manch();
    logic [3:0] q;
    for (int k = 0; k < 8; k++) begin
      wr(`PLCD_ADDR_FILT, {3'(k), 5'b00111}, 4'h1);
      for (int j = 0; j < 3; j++) begin
        q = (j == 0) ? 4'hf : (j == 1 ? 4'(k) : (k == 0 ? 4'h0 : 4'(k - 1)));
        mq_value <= q;
        mq_valid <= 1'b1;
        @(posedge aclk);
        mq_valid <= 1'b0;
        cyc_wait(2);
        chk(manchester_violation, (k != 0 && q < k));
        rchk(`PLCD_ADDR_MANCH, 32'h1f, {(k != 0 && q < k), (q == 4'hf ? 4'he : q)});
      end
    end
    wr(`PLCD_ADDR_FILT, 8'he6, 4'h1);
    cyc_wait(2);
    chk({demod.demod_reset_n, manchester_violation}, 2'b00);
    wr(`PLCD_ADDR_FILT, 8'he7, 4'h1);
    cyc_wait(2);
    chk(demod.demod_reset_n, 1'b1);
  endtask

  task automatic t_filter();
    logic [6:0] st [4];
    st = '{7'd11, 7'd22, 7'd43, 7'd86};
    for (int i = 0; i < 8; i++) begin
      wr(`PLCD_ADDR_FILT, {3'h3, i[1], i[2], i[1:0], 1'b1}, 4'h1);
      auto_avg_lock <= i[0];
      cyc_wait(3);
      chk(demod.settle_baud, st[i[1:0]]);
      chk(demod.avg_filter_locked_out, i[2] ? i[1] : i[0]);
    end
    wr(`PLCD_ADDR_PEAK, 8'h2a, 4'h1);
    cyc_wait(2);
    chk({demod.peak_remover_enable, demod.peak_threshold}, 8'h2a);
    rchk(`PLCD_ADDR_PEAK, 32'hff, 32'h2a);
  endtask

  initial begin
    do_reset();
    t_reset_bus();
    t_pins();
    t_lock(1'b1, 1'b0);
    t_lock(1'b0, 1'b0);
    t_lock(1'b1, 1'b1);
    t_cal(1'b1, 1'b0, 1'b0, 3'h1, 8'h02, 1'b0, 8'h02, 8'h02);
    t_cal(1'b0, 1'b1, 1'b1, 3'h2, 8'h05, 1'b1, 8'h02, 8'h05);
    t_cal(1'b0, 1'b0, 1'b0, 3'h7, 8'hc3, 1'b0, 8'hc3, 8'h05);
    t_cal(1'b0, 1'b0, 1'b0, 3'h0, 8'h05, 1'b1, 8'hc3, 8'h01);
    // Trigger bit already set: no new run, done stays set
    wr(`PLCD_ADDR_TUNE, 8'h80, 4'h1);
    rchk(`PLCD_ADDR_TUNE, 32'h8, 32'h8);
    t_manch();
    t_filter();
    end_sim();
  end
endmodule
